// >>> hdl/fdcs_cnt.sv
`timescale 1ns/1ps
module fdcs_cnt #(
    parameter int W = 4
) (
    input  wire logic         clock_in,
    input  wire logic         rstn_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    output logic              last_out
);
    typedef struct packed {
        logic [W-1:0] count;
    } fdcs_cnt_s;

    fdcs_cnt_s q;
    fdcs_cnt_s d;

    // high in the final cycle of a loaded run
    assign last_out = (q.count == W'(1));

    always_comb begin
        d = q;
        if (load_in) begin
            d.count = value_in;
        end else if (q.count != '0) begin
            d.count = q.count - 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// >>> hdl/fdcs_fifo.sv
`timescale 1ns/1ps
module fdcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_in,
    input  wire logic             rstn_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
        logic                        not_full;
    } fdcs_fifo_s;

    fdcs_fifo_s q;
    fdcs_fifo_s d;
    logic       push;
    logic       pop;

    assign push          = in_valid_in && q.not_full;
    assign pop           = out_ready_in && (q.count != '0);
    assign in_ready_out  = q.not_full;
    assign out_valid_out = (q.count != '0);
    assign out_data_out  = q.mem[q.rd_ptr];

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr_ptr] = in_data_in;
            d.wr_ptr        = (q.wr_ptr == PW'(DEPTH - 1)) ? '0
                              : q.wr_ptr + 1'b1;
        end
        if (pop) begin
            d.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0
                       : q.rd_ptr + 1'b1;
        end
        d.count    = q.count + (PW+1)'(push) - (PW+1)'(pop);
        d.not_full = (d.count != (PW+1)'(DEPTH));
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q          <= '0;
            q.not_full <= 1'b1;
        end else begin
            q <= d;
        end
    end
endmodule

// >>> hdl/fdcs_pkg.sv
package fdcs_pkg;

    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 64;
    localparam int LANES      = 8;
    localparam int STAT_W     = 2;
    localparam int TO_W       = 4;
    localparam int FIFO_DEPTH = 8;

    // status codes and strobe level, overridable at the top
    localparam logic [STAT_W-1:0] STAT_IDLE_DEF = 2'h0;
    localparam logic [STAT_W-1:0] STAT_ACT_DEF  = 2'h1;
    localparam logic              CAS_ACT_DEF   = 1'b0;

    // least RAS high cycles before the row strobe may fall
    localparam logic [1:0]      RAS_HI_MIN     = 2'h3;
    // extra cycles after ras_low2 for writes with exceptions on
    localparam logic [TO_W-1:0] EXC_INSERT_CYC = 4'h2;

    typedef enum logic [3:0] {
        ST_ROW1,
        ST_ROW2,
        ST_RAS_HW,
        ST_RAS_L1,
        ST_RAS_L2,
        ST_EXC_INS,
        ST_EXC_RET,
        ST_COL,
        ST_TURNOFF
    } fdcs_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic              write;
        logic              packet;
        logic [LANES-1:0]  lanes;
        logic [DATA_W-1:0] data;
    } fdcs_req_s;

    typedef struct packed {
        logic              ready;
        logic              exception;
        logic              exc_en;
        logic [TO_W-1:0]   turnoff;
    } fdcs_ctl_s;

endpackage

// >>> hdl/fdcs_seq.sv
`timescale 1ns/1ps
module fdcs_seq #(
    parameter logic [1:0] STAT_IDLE = fdcs_pkg::STAT_IDLE_DEF,
    parameter logic [1:0] STAT_ACT  = fdcs_pkg::STAT_ACT_DEF,
    parameter logic       CAS_ACT   = fdcs_pkg::CAS_ACT_DEF,
    parameter int         DEPTH     = fdcs_pkg::FIFO_DEPTH
) (
    input  wire logic                            clock_in,
    input  wire logic                            rstn_in,
    input  wire logic                            req_valid_in,
    output logic                                 req_ready_out,
    input  wire fdcs_pkg::fdcs_req_s             req_in,
    input  wire fdcs_pkg::fdcs_ctl_s             ctl_in,
    output logic                                 ras_n_out,
    output logic [fdcs_pkg::LANES-1:0]           cas_out,
    output logic [fdcs_pkg::STAT_W-1:0]          status_out,
    output logic [fdcs_pkg::ADDR_W-1:0]          row_col_addr_bus_out,
    input  wire logic [fdcs_pkg::DATA_W-1:0]     muxed_bus_in,
    output logic [fdcs_pkg::DATA_W-1:0]          muxed_bus_out,
    output logic                                 muxed_bus_oe_out,
    output logic [fdcs_pkg::DATA_W-1:0]          rd_data_out,
    output logic                                 rd_valid_out
);
    import fdcs_pkg::*;

    typedef struct packed {
        logic              rdy_s1;
        logic              rdy_s2;
        logic              exc_s1;
        logic              exc_s2;
        fdcs_state_e       st;
        logic [ADDR_W-1:0] open_row;
        logic              write;
        logic              packet;
        logic              exc_en;
        logic [TO_W-1:0]   turnoff;
        logic [1:0]        ras_hi;
        logic              c1;
        logic              c2;
        logic              ras_n;
        logic [LANES-1:0]  cas;
        logic [STAT_W-1:0] status;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              oe;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
    } fdcs_seq_s;

    localparam logic [LANES-1:0] CAS_OFF = {LANES{~CAS_ACT}};

    fdcs_seq_s q;
    fdcs_seq_s d;

    fdcs_req_s       head;
    logic            head_valid;
    logic            pop;
    logic            start;
    logic            cnt_load;
    logic [TO_W-1:0] cnt_value;
    logic            cnt_last;
    logic [TO_W-1:0] need_to;

    fdcs_fifo #(
        .WIDTH ($bits(fdcs_req_s)),
        .DEPTH (DEPTH)
    ) fdcs_fifo_i (
        .clock_in      (clock_in),
        .rstn_in       (rstn_in),
        .in_valid_in   (req_valid_in),
        .in_ready_out  (req_ready_out),
        .in_data_in    (req_in),
        .out_valid_out (head_valid),
        .out_ready_in  (pop),
        .out_data_out  (head)
    );

    fdcs_cnt #(
        .W (TO_W)
    ) fdcs_cnt_i (
        .clock_in (clock_in),
        .rstn_in  (rstn_in),
        .load_in  (cnt_load),
        .value_in (cnt_value),
        .last_out (cnt_last)
    );

    // column start only for the open row in the same direction
    assign start = head_valid && (head.row == q.open_row)
                   && (head.write == q.write);
    // turnoff count that applies when this row is closed
    assign need_to = (!q.write || q.packet) ? q.turnoff : '0;

    always_comb begin
        d        = q;
        pop      = 1'b0;
        cnt_load = 1'b0;
        cnt_value = '0;
        d.rdy_s1 = ctl_in.ready;
        d.rdy_s2 = q.rdy_s1;
        d.exc_s1 = ctl_in.exception;
        d.exc_s2 = q.exc_s1;
        d.status = STAT_IDLE;
        d.cas    = CAS_OFF;
        d.oe     = 1'b0;
        d.c1     = 1'b0;
        d.c2     = q.c1;
        d.rvalid = 1'b0;
        d.ras_hi = !q.ras_n ? 2'h0
                   : (q.ras_hi == 2'h3) ? q.ras_hi : q.ras_hi + 2'h1;
        // capture runs apart from the state machine
        if (q.c2) begin
            d.rdata  = muxed_bus_in;
            d.rvalid = 1'b1;
        end
        unique case (q.st)
            ST_ROW1: begin
                if (head_valid) begin
                    d.open_row = head.row;
                    d.addr     = head.row;
                    d.write    = head.write;
                    d.packet   = head.packet;
                    d.exc_en   = ctl_in.exc_en;
                    d.turnoff  = ctl_in.turnoff;
                    d.st       = ST_ROW2;
                end
            end
            ST_ROW2: begin
                if (q.exc_en && q.exc_s2) begin
                    d.st = ST_EXC_RET;
                end else if (q.rdy_s2) begin
                    if (q.ras_hi < RAS_HI_MIN - 2'h1) begin
                        d.st = ST_RAS_HW;
                    end else begin
                        d.st    = ST_RAS_L1;
                        d.ras_n = 1'b0;
                    end
                end
            end
            ST_RAS_HW: begin
                d.st    = ST_RAS_L1;
                d.ras_n = 1'b0;
            end
            ST_RAS_L1: begin
                d.st = ST_RAS_L2;
            end
            ST_RAS_L2: begin
                if (q.rdy_s2) begin
                    if (q.write && q.exc_en) begin
                        cnt_load  = 1'b1;
                        cnt_value = EXC_INSERT_CYC;
                        d.st      = ST_EXC_INS;
                    end else begin
                        d.st = ST_COL;
                    end
                end
            end
            ST_EXC_INS: begin
                if (cnt_last) begin
                    d.st = ST_COL;
                end
            end
            ST_EXC_RET: begin
                d.st = ST_ROW1;
            end
            ST_COL: begin
                if (start) begin
                    pop      = 1'b1;
                    d.status = STAT_ACT;
                    d.addr   = head.col;
                    if (q.write) begin
                        d.cas   = CAS_ACT ? head.lanes : ~head.lanes;
                        d.wdata = head.data;
                        d.oe    = 1'b1;
                    end else begin
                        d.cas = {LANES{CAS_ACT}};
                        d.c1  = 1'b1;
                    end
                end else if (head_valid && !q.c1 && !q.c2) begin
                    // new row: leave only once the pipe is empty
                    d.ras_n = 1'b1;
                    if (need_to != '0) begin
                        cnt_load  = 1'b1;
                        cnt_value = need_to;
                        d.st      = ST_TURNOFF;
                    end else begin
                        d.st = ST_ROW1;
                    end
                end
                // otherwise a bubble: idle status, strobes off
            end
            ST_TURNOFF: begin
                if (cnt_last) begin
                    d.st = ST_ROW1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q        <= '0;
            q.st     <= ST_ROW1;
            q.ras_n  <= 1'b1;
            q.cas    <= CAS_OFF;
            q.status <= STAT_IDLE;
        end else begin
            q <= d;
        end
    end

    assign ras_n_out            = q.ras_n;
    assign cas_out              = q.cas;
    assign status_out           = q.status;
    assign row_col_addr_bus_out = q.addr;
    assign muxed_bus_out        = q.wdata;
    assign muxed_bus_oe_out     = q.oe;
    assign rd_data_out          = q.rdata;
    assign rd_valid_out         = q.rvalid;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_exc_seen;
        q.st == ST_ROW2 && q.exc_en && q.exc_s2;
    endsequence

    sequence s_abort_path;
        q.st == ST_EXC_RET ##1 q.st == ST_ROW1;
    endsequence

    sequence s_read_start;
        status_out == STAT_ACT && !muxed_bus_oe_out;
    endsequence

    sequence s_exc_write_gap;
        q.st == ST_EXC_INS [*2] ##1 q.st == ST_COL;
    endsequence

    row_order_a: assert property (
        q.st == ST_RAS_L1 |->
            $past(q.st) == ST_ROW2 || $past(q.st) == ST_RAS_HW)
        else $error("ras_low1 entered from a wrong state");

    ready_hold_a: assert property (
        (q.st == ST_ROW2 || q.st == ST_RAS_L2) && !q.rdy_s2
            && !(q.exc_en && q.exc_s2) |=> $stable(q.st))
        else $error("wait state not held while ready low");

    ras_high_a: assert property (
        $fell(ras_n_out) |->
            $past(ras_n_out, 2) && $past(ras_n_out, 3))
        else $error("RAS high shorter than three cycles");

    exc_abort_a: assert property (
        s_exc_seen |=> s_abort_path)
        else $error("exception did not abort the row access");

    read_capture_a: assert property (
        s_read_start |-> cas_out == {LANES{CAS_ACT}} ##2 rd_valid_out)
        else $error("read data not captured two cycles on");

    idle_strobe_a: assert property (
        status_out == STAT_IDLE |-> cas_out == CAS_OFF && !muxed_bus_oe_out)
        else $error("strobe or data driven with idle status");

    drain_first_a: assert property (
        $rose(ras_n_out) && $past(q.st) == ST_COL |->
            !$past(q.c1) && !$past(q.c2))
        else $error("row closed with an access in flight");

    exc_gap_a: assert property (
        q.st == ST_RAS_L2 && q.rdy_s2 && q.write && q.exc_en
            |=> s_exc_write_gap)
        else $error("exception spacing for writes not met");

    write_lane_a: assert property (
        muxed_bus_oe_out |-> status_out == STAT_ACT
            && !q.c2 ##1 !rd_valid_out)
        else $error("write drive outside a column access");

    turnoff_skip_a: assert property (
        q.st == ST_ROW1 && $past(q.st) == ST_COL |->
            $past(need_to) == '0)
        else $error("turnoff cycles skipped");

    single_bubble_a: assert property (
        s_read_start ##1 (status_out == STAT_IDLE && q.st == ST_COL)
            |-> q.c2 ##1 rd_valid_out)
        else $error("bubble lost an in-flight read");

    row_open_a: assert property (
        q.st == ST_COL |-> !ras_n_out)
        else $error("row closed while in column state");

    load_next_a: assert property (
        q.st == ST_COL && start |=> status_out == STAT_ACT)
        else $error("queued column access not loaded");

    long_bubble_a: assert property (
        s_read_start ##1 (status_out == STAT_IDLE) [*2] |=> !rd_valid_out)
        else $error("capture after the pipeline drained");

    exc_ras_a: assert property (
        q.st == ST_EXC_RET |-> ras_n_out)
        else $error("row strobe low during an abort");

    turnoff_ras_a: assert property (
        q.st == ST_TURNOFF |-> ras_n_out && status_out == STAT_IDLE)
        else $error("turnoff cycle with row or column active");

    cfg_hold_a: assert property (
        q.st != ST_ROW1 |=> $stable(q.exc_en) && $stable(q.turnoff))
        else $error("bank config changed inside a row access");
endmodule

// >>> testbench/fdcs_mem_model.sv
`timescale 1ns/1ps
module fdcs_mem_model (
    input  wire logic                        clock_in,
    input  wire logic                        ras_n_in,
    input  wire logic [fdcs_pkg::LANES-1:0]  cas_in,
    input  wire logic                        oe_in,
    input  wire logic [fdcs_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                        stall_in,
    input  wire logic                        fault_in,
    output logic      [fdcs_pkg::DATA_W-1:0] dq_out,
    output logic                             ready_out,
    output logic                             exc_out
);
    import fdcs_pkg::*;
    import fdcs_tb_pkg::*;

    logic [ADDR_W-1:0] row_q;

    initial begin
        row_q = '0;
        dq_out = '1;
    end

    // wait states and faults only when the bench commands them
    assign ready_out = !stall_in;
    assign exc_out   = fault_in;

    always @(posedge clock_in) begin
        if (ras_n_in)
            row_q <= addr_in;
        // data valid one cycle after all strobes, else a moving pattern
        if (!ras_n_in && !oe_in && cas_in === {LANES{CAS_ACT_DEF}})
            dq_out <= fdcs_dat(row_q, addr_in);
        else
            dq_out <= ~dq_out;
    end
endmodule

// >>> testbench/fdcs_seq_tb.sv
`timescale 1ns/1ps
module fdcs_seq_tb;
    import fdcs_pkg::*;
    import fdcs_tb_pkg::*;

    localparam logic [LANES-1:0] C_ON = {LANES{CAS_ACT_DEF}};

    logic              clock_in;
    logic              rstn_in;
    logic              req_valid_in;
    logic              req_ready_out;
    fdcs_req_s         req_in;
    fdcs_ctl_s         ctl_in;
    logic              ras_n_out;
    logic [LANES-1:0]  cas_out;
    logic [STAT_W-1:0] status_out;
    logic [ADDR_W-1:0] addr_out;
    logic [DATA_W-1:0] dq_in;
    logic [DATA_W-1:0] dq_out;
    logic              oe_out;
    logic [DATA_W-1:0] rd_data_out;
    logic              rd_valid_out;
    logic              m_ready;
    logic              m_exc;
    logic              stall;
    logic              fault;
    logic              cfg_exc;
    logic [TO_W-1:0]   cfg_to;
    int                n_errors = 0;
    int                cmp_count = 0;
    int                cyc = 0;
    int                act_n = 0;
    int                rise_t = 0;
    int                fall_t = 0;
    int                act_t [int];
    int                hi_q [$];
    int                gap_q [$];
    bit                gap_wait = 0;
    bit                ras_p = 1;
    bit [1:0]          rdp = '0;
    fdcs_req_s         exp_q [$];
    logic [DATA_W-1:0] rd_q [$];

    fdcs_row_s rows [7] = '{
        '{1'b0, 1'b0, 1'b0, 4'h4, 8'hFF, 4'h4, 4'h0},
        '{1'b0, 1'b0, 1'b1, 4'h6, 8'hFF, 4'h6, 4'h0},
        '{1'b1, 1'b0, 1'b0, 4'h4, 8'h0F, 4'h0, 4'h0},
        '{1'b1, 1'b0, 1'b1, 4'h6, 8'hA5, 4'h0, EXC_INSERT_CYC},
        '{1'b1, 1'b1, 1'b0, 4'h4, 8'h81, 4'h4, 4'h0},
        '{1'b1, 1'b1, 1'b0, 4'h6, 8'h7E, 4'h6, 4'h0},
        '{1'b0, 1'b0, 1'b0, 4'h0, 8'hFF, 4'h0, 4'h0}
    };

    assign ctl_in = {m_ready, m_exc, cfg_exc, cfg_to};

    always #2.5 clock_in = ~clock_in;

    fdcs_seq fdcs_seq_i (
        .clock_in(clock_in), .rstn_in(rstn_in),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_in(req_in), .ctl_in(ctl_in), .ras_n_out(ras_n_out),
        .cas_out(cas_out), .status_out(status_out),
        .row_col_addr_bus_out(addr_out), .muxed_bus_in(dq_in),
        .muxed_bus_out(dq_out), .muxed_bus_oe_out(oe_out),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out)
    );

    fdcs_mem_model fdcs_mem_model_i (
        .clock_in(clock_in), .ras_n_in(ras_n_out), .cas_in(cas_out),
        .oe_in(oe_out), .addr_in(addr_out), .stall_in(stall),
        .fault_in(fault), .dq_out(dq_in), .ready_out(m_ready),
        .exc_out(m_exc)
    );

    task automatic check(input bit ok, input string what);
        cmp_count++;
        if (!ok) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic fdcs_req_s mk(input int r, input int c,
                                     input fdcs_row_s w);
        fdcs_req_s q;
        q.row = r[ADDR_W-1:0];
        q.col = c[ADDR_W-1:0];
        q.write = w.wr;
        q.packet = w.pkt;
        q.lanes = w.lanes;
        q.data = fdcs_dat(q.row, q.col);
        return q;
    endfunction

    task automatic push(input int r, input int c, input fdcs_row_s w);
        int n;
        n = 0;
        req_in <= mk(r, c, w);
        req_valid_in <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (req_ready_out !== 1'b1 && n < 300);
        check(n < 300, "request not taken");
        exp_q.push_back(mk(r, c, w));
    endtask

    task automatic idle(input int n);
        req_valid_in <= 1'b0;
        repeat (n) @(posedge clock_in);
    endtask

    task automatic quiet();
        int n;
        n = 0;
        req_valid_in <= 1'b0;
        do begin
            @(posedge clock_in);
            n++;
        end while ((exp_q.size() != 0 || rdp != 0) && n < 500);
        check(n < 500, "accesses did not finish");
        repeat (2) @(posedge clock_in);
    endtask

    // port monitor: column starts, strobes, captures, RAS timing
    always @(posedge clock_in) begin
        fdcs_req_s e;
        bit        ok;
        if (rstn_in === 1'b1) begin
            cyc++;
            if (ras_p && ras_n_out === 1'b0) begin
                hi_q.push_back(cyc - rise_t);
                check(cyc - rise_t >= 3, "ras high too short");
                fall_t = cyc;
                gap_wait = 1;
            end
            if (!ras_p && ras_n_out === 1'b1)
                rise_t = cyc;
            ras_p = (ras_n_out === 1'b1);
            ok = rdp[1] && rd_data_out === rd_q.pop_front();
            if (rd_valid_out === 1'b1)
                check(ok, "read capture");
            else
                check(!rdp[1], "read capture missing");
            rdp = {rdp[0], 1'b0};
            if (status_out === STAT_ACT_DEF) begin
                e = exp_q.pop_front();
                act_t[act_n] = cyc;
                act_n++;
                if (gap_wait)
                    gap_q.push_back(cyc - fall_t);
                gap_wait = 0;
                check(addr_out === e.col, "column address");
                if (e.write) begin
                    ok = cas_out === ~(e.lanes ^ C_ON) && oe_out === 1'b1;
                    check(ok && dq_out === e.data, "write column");
                end else begin
                    ok = cas_out === C_ON && oe_out === 1'b0;
                    check(ok, "read strobes");
                    rd_q.push_back(fdcs_dat(e.row, e.col));
                    rdp[0] = 1'b1;
                end
            end else begin
                ok = cas_out === ~C_ON && oe_out === 1'b0;
                check(ok, "idle strobes");
            end
        end
    end

    initial begin
        #50000;
        n_errors++;
        complete_run();
    end

    initial begin
        int taken;
        int falls;
        bit ok;
        clock_in = 1'b0;
        rstn_in = 1'b0;
        req_valid_in = 1'b0;
        req_in = '0;
        stall = 1'b0;
        fault = 1'b0;
        cfg_exc = 1'b0;
        cfg_to = '0;
        repeat (10) @(posedge clock_in);
        ok = ras_n_out === 1'b1 && cas_out === ~C_ON && oe_out === 1'b0;
        ok = ok && status_out === STAT_IDLE_DEF && rd_valid_out === 1'b0;
        check(ok && req_ready_out === 1'b1, "reset values");
        rstn_in <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            cfg_exc <= rows[k].exc;
            cfg_to <= rows[k].to;
            for (int j = 0; j < 3; j++)
                push(k + 1, k * 16 + j, rows[k]);
            quiet();
        end
        for (int k = 1; k < 7; k++) begin
            check(gap_q[k] - gap_q[0] == rows[k].ins, "row to column");
            ok = hi_q[k] == ((rows[k-1].eto > 1) ? rows[k-1].eto + 2 : 3);
            check(ok, "turnoff length");
        end
        // exception with exceptions enabled keeps retrying the row
        cfg_exc <= 1'b1;
        cfg_to <= '0;
        fault <= 1'b1;
        push(20, 0, rows[6]);
        idle(40);
        check(ras_n_out === 1'b1 && exp_q.size() == 1, "abort");
        fault <= 1'b0;
        quiet();
        cfg_exc <= 1'b0;
        fault <= 1'b1;
        push(21, 0, rows[6]);
        quiet();
        fault <= 1'b0;
        // wait states keep RAS high while the queue fills
        stall <= 1'b1;
        repeat (4) @(posedge clock_in);
        taken = 0;
        for (int j = 0; j < 12; j++) begin
            req_in <= mk(22, taken, rows[6]);
            req_valid_in <= 1'b1;
            @(posedge clock_in);
            if (req_ready_out === 1'b1) begin
                exp_q.push_back(req_in);
                taken++;
            end
        end
        check(taken == FIFO_DEPTH, "queue depth");
        check(ras_n_out === 1'b1 && act_n == 7 * 3 + 2, "wait states");
        stall <= 1'b0;
        quiet();
        // bubbles on an open row
        falls = hi_q.size();
        push(22, 40, rows[6]);
        push(22, 41, rows[6]);
        idle(1);
        push(22, 42, rows[6]);
        idle(3);
        push(22, 43, rows[6]);
        quiet();
        check(act_t[act_n-3] - act_t[act_n-4] == 1, "back to back");
        check(act_t[act_n-2] - act_t[act_n-3] == 2, "one bubble");
        check(act_t[act_n-1] - act_t[act_n-2] == 4, "long bubble");
        check(hi_q.size() == falls, "row kept open");
        complete_run();
    end
endmodule

// >>> testbench/fdcs_tb_pkg.sv
package fdcs_tb_pkg;
    import fdcs_pkg::*;

    typedef struct packed {
        logic            wr;
        logic            pkt;
        logic            exc;
        logic [TO_W-1:0] to;
        logic [7:0]      lanes;
        logic [TO_W-1:0] eto;
        logic [TO_W-1:0] ins;
    } fdcs_row_s;

    // memory contents as a pure function of row and column
    function automatic logic [DATA_W-1:0] fdcs_dat(
        input logic [ADDR_W-1:0] r,
        input logic [ADDR_W-1:0] c
    );
        return {30'h2AC35A0F, r, c};
    endfunction

endpackage
